// *** hdl/pdmac_consts.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the peripheral DMA channel
// Assumes: 32-bit register words on an AXI4-Lite slave with an 8-bit byte address
// Notes: definitions only
`ifndef PDMAC_CONSTS_SVH
`define PDMAC_CONSTS_SVH

// register byte offsets
`define PDMAC_OFF_CTRL 8'h00
`define PDMAC_OFF_STAT 8'h04
`define PDMAC_OFF_PADDR 8'h08
`define PDMAC_OFF_MADDR 8'h0C
`define PDMAC_OFF_MASK 8'h10

// channel_control_status fields
`define PDMAC_CR_EN 0
`define PDMAC_CR_DIR 1
`define PDMAC_CR_SIZE 2
`define PDMAC_CR_PERSEL 8
`define PDMAC_CR_ERRSTOP 15
`define PDMAC_CR_CNT 16
`define PDMAC_CNT_W 12
`define PDMAC_CR_WMASK 32'h0FFF_BF0F

// status and mask fields
`define PDMAC_ST_DONE 0
`define PDMAC_ST_ERR 1

// reset values
`define PDMAC_CTRL_RST 32'h0000_0000
`define PDMAC_POFF_RST 16'h0000
`define PDMAC_MOFF_RST 15'h0000
`define PDMAC_FLAGS_RST 2'h0

// fixed address halves
`define PDMAC_PERIPH_BASE 16'h4000
`define PDMAC_MEM_BASE 16'h2000

// peripheral access latency in clock cycles
`define PDMAC_PERIPH_LAT 3'h4

// bus encodings
`define PDMAC_RESP_OKAY 2'h0
`define PDMAC_RESP_SLVERR 2'h2
`define PDMAC_HTRANS_IDLE 2'h0
`define PDMAC_HTRANS_NONSEQ 2'h2

`endif

// *** hdl/pdmac_pkg.sv ***
// Purpose: types of the peripheral DMA channel
// Assumes: constants come from pdmac_consts.svh
// Notes: none
package pdmac_pkg;
   typedef enum logic [1:0] {CH_IDLE, CH_READ, CH_WRITE} pdmac_ch_t;
   typedef enum logic [2:0] {EN_IDLE, EN_LAT, EN_REQ, EN_ADDR, EN_DATA, EN_YIELD} pdmac_eng_t;
endpackage

// *** hdl/pdmac_ahb_port.sv ***
// Purpose: one single AHB master transfer per start pulse, with peripheral latency and bus yield
// Assumes: arbiter keeps grant while the request stays high
// Notes: read data come back right-aligned by size
`timescale 1ns/1ps
`include "pdmac_consts.svh"
module pdmac_ahb_port import pdmac_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic start,
   input wire logic is_periph,
   input wire logic [31:0] addr_in,
   input wire logic wr_in,
   input wire logic [1:0] size_in,
   input wire logic [31:0] wdata_in,
   output logic done,
   output logic err,
   output logic [31:0] rdata,
   output logic hbusreq,
   input wire logic hgrant,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hready,
   input wire logic hresp
);
   pdmac_eng_t st_r, st_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [31:0] addr_r, addr_nxt, wbuf_r, wbuf_nxt, hwdata_r, hwdata_nxt, rdata_r, rdata_nxt;
   logic [1:0] size_r, size_nxt, htrans_r, htrans_nxt;
   logic wr_r, wr_nxt, req_r, req_nxt, done_r, done_nxt, err_r, err_nxt;
   logic [31:0] shifted;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      addr_nxt = addr_r;
      wbuf_nxt = wbuf_r;
      size_nxt = size_r;
      wr_nxt = wr_r;
      req_nxt = req_r;
      htrans_nxt = htrans_r;
      hwdata_nxt = hwdata_r;
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      done_nxt = 1'b0;
      shifted = hrdata >> {addr_r[1:0], 3'b000};
      case (st_r)
         EN_IDLE: begin
            if (start) begin
               addr_nxt = addr_in;
               wr_nxt = wr_in;
               size_nxt = size_in;
               wbuf_nxt = wdata_in;
               if (is_periph) begin
                  st_nxt = EN_LAT;
                  cnt_nxt = `PDMAC_PERIPH_LAT - 3'h1;
               end else begin
                  st_nxt = EN_REQ;
                  req_nxt = 1'b1;
               end
            end
         end
         EN_LAT: begin
            if (cnt_r == 3'h0) begin
               st_nxt = EN_REQ;
               req_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         EN_REQ: begin
            if (hgrant && hready) begin
               st_nxt = EN_ADDR;
               htrans_nxt = `PDMAC_HTRANS_NONSEQ;
            end
         end
         EN_ADDR: begin
            if (hready) begin
               st_nxt = EN_DATA;
               htrans_nxt = `PDMAC_HTRANS_IDLE;
               req_nxt = 1'b0;
               case (size_r)
                  2'h0: hwdata_nxt = {4{wbuf_r[7:0]}};
                  2'h1: hwdata_nxt = {2{wbuf_r[15:0]}};
                  default: hwdata_nxt = wbuf_r;
               endcase
            end
         end
         EN_DATA: begin
            if (hready) begin
               st_nxt = EN_YIELD;
               done_nxt = 1'b1;
               err_nxt = hresp;
               case (size_r)
                  2'h0: rdata_nxt = {24'h000000, shifted[7:0]};
                  2'h1: rdata_nxt = {16'h0000, shifted[15:0]};
                  default: rdata_nxt = hrdata;
               endcase
            end
         end
         EN_YIELD: st_nxt = EN_IDLE;
         default: st_nxt = EN_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= EN_IDLE;
         cnt_r <= 3'h0;
         addr_r <= 32'h0000_0000;
         wbuf_r <= 32'h0000_0000;
         size_r <= 2'h0;
         wr_r <= 1'b0;
         req_r <= 1'b0;
         htrans_r <= `PDMAC_HTRANS_IDLE;
         hwdata_r <= 32'h0000_0000;
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
         done_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         addr_r <= addr_nxt;
         wbuf_r <= wbuf_nxt;
         size_r <= size_nxt;
         wr_r <= wr_nxt;
         req_r <= req_nxt;
         htrans_r <= htrans_nxt;
         hwdata_r <= hwdata_nxt;
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;
   assign err = err_r;
   assign rdata = rdata_r;
   assign hbusreq = req_r;
   assign haddr = addr_r;
   assign htrans = htrans_r;
   assign hwrite = wr_r;
   assign hsize = {1'b0, size_r};
   assign hwdata = hwdata_r;

   sequence lat_quiet_s;
      !req_r [*4];
   endsequence
   sequence lat_then_req_s;
      lat_quiet_s ##1 req_r;
   endsequence
   periph_latency_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      (st_r == EN_IDLE && start && is_periph) |=> lat_then_req_s)
      else $error("peripheral access did not wait four cycles");
   bus_yield_a: assert property (@(posedge clk) disable iff (!resetn)
      done_r |-> !req_r ##1 !req_r)
      else $error("bus request not released after a transfer");
endmodule

// *** hdl/pdmac_channel.sv ***
// Summary of operation
// - memory address bit 15 always reads zero and ignores writes
// - after each transfer memory offset grows by two to the size code, and by four for size code 3
// - halfword size ignores memory offset bit 0 when addressing
// - word size ignores memory offset bits 1 and 0 when addressing
// - direction 0 reads from memory, direction 1 writes to memory
// - one of two bus masters, yields after each access for round-robin
// - transfers start only on a request from the selected peripheral
// - each request reads one datum into a buffer then writes it out
// - a peripheral request stays pending until its source read is issued or enable clears
// - remaining transfer count drops by one after each datum moves
// - count reaching zero sets the end-of-transfer flag and interrupt source
// - peripheral accesses take four cycles, plus waits while the bus is taken
// - setting enable starts the channel; hardware clears it when done
// - peripheral address upper half reads 0x4000; lower half is the offset
// - enable also clears itself right after a transfer error
//
// Purpose: one peripheral-triggered DMA channel with AXI4-Lite registers and an AHB master port
// Assumes: request, error, AHB and AXI inputs are all on CORE_CLK
// Notes: status bits clear on read; size code 3 is handled as word
`timescale 1ns/1ps
`include "pdmac_consts.svh"
module pdmac_channel import pdmac_pkg::*; #(
   parameter int NREQ = 34
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic HBUSREQ,
   input wire logic HGRANT,
   output logic [31:0] HADDR,
   output logic [1:0] HTRANS,
   output logic HWRITE,
   output logic [2:0] HSIZE,
   output logic [31:0] HWDATA,
   input wire logic [31:0] HRDATA,
   input wire logic HREADY,
   input wire logic HRESP,
   input wire logic [NREQ-1:0] PERIPH_REQ,
   input wire logic [NREQ-1:0] PERIPH_ERR,
   output logic IRQ
);
   // bus slave state
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt, awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   // channel state
   logic [31:0] ctrl_r, ctrl_nxt, buf_r, buf_nxt, eaddr_r, eaddr_nxt;
   logic [15:0] poff_r, poff_nxt;
   logic [14:0] moff_r, moff_nxt;
   logic [1:0] stat_r, stat_nxt, mask_r, mask_nxt;
   logic pend_r, pend_nxt, reqd_r, reqd_nxt, irq_r, irq_nxt, est_r, est_nxt, ewr_r, ewr_nxt, eper_r, eper_nxt;
   pdmac_ch_t ch_r, ch_nxt;
   // derived
   logic wr_fire, rd_fire, en, dir, errstop, sel_req, sel_err, e_done, e_err;
   logic [1:0] sz;
   logic [5:0] persel;
   logic [`PDMAC_CNT_W-1:0] cnt;
   logic [14:0] inc, moff_eff;
   logic [31:0] mem_addr, per_addr, e_rdata;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign en = ctrl_r[`PDMAC_CR_EN];
   assign dir = ctrl_r[`PDMAC_CR_DIR];
   assign errstop = ctrl_r[`PDMAC_CR_ERRSTOP];
   assign persel = ctrl_r[`PDMAC_CR_PERSEL +: 6];
   assign cnt = ctrl_r[`PDMAC_CR_CNT +: `PDMAC_CNT_W];
   assign sz = (ctrl_r[`PDMAC_CR_SIZE +: 2] == 2'h3) ? 2'h2 : ctrl_r[`PDMAC_CR_SIZE +: 2];
   // selection 0 is the idle code, so its line never triggers anything
   assign sel_req = (persel != 6'h00) && (int'(persel) < NREQ) && PERIPH_REQ[persel];
   assign sel_err = (persel != 6'h00) && (int'(persel) < NREQ) && PERIPH_ERR[persel];
   assign inc = 15'h0001 << sz;
   assign moff_eff = (sz == 2'h1) ? (moff_r & 15'h7FFE) : (sz == 2'h2) ? (moff_r & 15'h7FFC) : moff_r;
   assign mem_addr = {`PDMAC_MEM_BASE, 1'b0, moff_eff};
   assign per_addr = {`PDMAC_PERIPH_BASE, poff_r};
   assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
   assign rd_fire = S_AXI_ARVALID && arready_r;

   // bus slave: address and data may come in either order, one write and one read at a time
   always_comb begin
      aw_have_nxt = aw_have_r;
      awaddr_nxt = awaddr_r;
      w_have_nxt = w_have_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (S_AXI_AWVALID && awready_r) begin
         aw_have_nxt = 1'b1;
         awaddr_nxt = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_r) begin
         w_have_nxt = 1'b1;
         wdata_nxt = S_AXI_WDATA;
         wstrb_nxt = S_AXI_WSTRB;
      end
      if (bvalid_r && S_AXI_BREADY) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_fire) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (awaddr_r inside {`PDMAC_OFF_CTRL, `PDMAC_OFF_STAT, `PDMAC_OFF_PADDR, `PDMAC_OFF_MADDR,
            `PDMAC_OFF_MASK}) ? `PDMAC_RESP_OKAY : `PDMAC_RESP_SLVERR;
      end
      if (rvalid_r && S_AXI_RREADY) begin
         rvalid_nxt = 1'b0;
      end
      if (rd_fire) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `PDMAC_RESP_OKAY;
         case (S_AXI_ARADDR)
            `PDMAC_OFF_CTRL: rdata_nxt = ctrl_r;
            `PDMAC_OFF_STAT: rdata_nxt = {30'h0000_0000, stat_r};
            `PDMAC_OFF_PADDR: rdata_nxt = per_addr;
            `PDMAC_OFF_MADDR: rdata_nxt = {`PDMAC_MEM_BASE, 1'b0, moff_r};
            `PDMAC_OFF_MASK: rdata_nxt = {30'h0000_0000, mask_r};
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = `PDMAC_RESP_SLVERR;
            end
         endcase
      end
      awready_nxt = !aw_have_nxt;
      wready_nxt = !w_have_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         aw_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         w_have_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         arready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `PDMAC_RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `PDMAC_RESP_OKAY;
      end else if (CLK_EN) begin
         aw_have_r <= aw_have_nxt;
         awaddr_r <= awaddr_nxt;
         w_have_r <= w_have_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         arready_r <= arready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // channel: register effects first, hardware events last so that a flag set wins over its read-clear
   always_comb begin
      ctrl_nxt = ctrl_r;
      poff_nxt = poff_r;
      moff_nxt = moff_r;
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      buf_nxt = buf_r;
      ch_nxt = ch_r;
      pend_nxt = pend_r;
      est_nxt = 1'b0;
      eaddr_nxt = eaddr_r;
      ewr_nxt = ewr_r;
      eper_nxt = eper_r;
      reqd_nxt = sel_req;
      if (rd_fire && S_AXI_ARADDR == `PDMAC_OFF_STAT) begin
         stat_nxt = 2'h0;
      end
      if (wr_fire) begin
         case (awaddr_r)
            `PDMAC_OFF_CTRL: ctrl_nxt = merge(ctrl_r, wdata_r, wstrb_r) & `PDMAC_CR_WMASK;
            `PDMAC_OFF_PADDR: poff_nxt = 16'(merge({16'h0000, poff_r}, wdata_r, wstrb_r));
            `PDMAC_OFF_MADDR: moff_nxt = 15'(merge({17'h00000, moff_r}, wdata_r, wstrb_r));
            `PDMAC_OFF_MASK: mask_nxt = 2'(merge({30'h0000_0000, mask_r}, wdata_r, wstrb_r));
            default: ;
         endcase
      end
      case (ch_r)
         CH_IDLE: begin
            if (en && pend_r) begin
               pend_nxt = 1'b0;
               est_nxt = 1'b1;
               eaddr_nxt = dir ? per_addr : mem_addr;
               ewr_nxt = 1'b0;
               eper_nxt = dir;
               ch_nxt = CH_READ;
            end
         end
         CH_READ: begin
            if (e_done) begin
               if (e_err || !en) begin
                  ch_nxt = CH_IDLE;
               end else begin
                  buf_nxt = e_rdata;
                  est_nxt = 1'b1;
                  eaddr_nxt = dir ? mem_addr : per_addr;
                  ewr_nxt = 1'b1;
                  eper_nxt = !dir;
                  ch_nxt = CH_WRITE;
               end
            end
         end
         CH_WRITE: begin
            if (e_done) begin
               ch_nxt = CH_IDLE;
               if (!e_err) begin
                  moff_nxt = moff_r + inc;
                  ctrl_nxt[`PDMAC_CR_CNT +: `PDMAC_CNT_W] = cnt - 12'h001;
                  if (cnt == 12'h001) begin
                     ctrl_nxt[`PDMAC_CR_EN] = 1'b0;
                     stat_nxt[`PDMAC_ST_DONE] = 1'b1;
                  end
               end
            end
         end
         default: ch_nxt = CH_IDLE;
      endcase
      // a bus error or a stopping peripheral error clears enable and sets the error flag; a write already under way still completes
      if ((e_done && e_err && ch_r != CH_IDLE) || (en && errstop && sel_err)) begin
         ctrl_nxt[`PDMAC_CR_EN] = 1'b0;
         stat_nxt[`PDMAC_ST_ERR] = 1'b1;
      end
      if (en && sel_req && !reqd_r) begin
         pend_nxt = 1'b1;
      end
      if (!ctrl_nxt[`PDMAC_CR_EN]) begin
         pend_nxt = 1'b0;
      end
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         ctrl_r <= `PDMAC_CTRL_RST;
         poff_r <= `PDMAC_POFF_RST;
         moff_r <= `PDMAC_MOFF_RST;
         stat_r <= `PDMAC_FLAGS_RST;
         mask_r <= `PDMAC_FLAGS_RST;
         buf_r <= 32'h0000_0000;
         ch_r <= CH_IDLE;
         pend_r <= 1'b0;
         reqd_r <= 1'b0;
         irq_r <= 1'b0;
         est_r <= 1'b0;
         eaddr_r <= 32'h0000_0000;
         ewr_r <= 1'b0;
         eper_r <= 1'b0;
      end else if (CLK_EN) begin
         ctrl_r <= ctrl_nxt;
         poff_r <= poff_nxt;
         moff_r <= moff_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         buf_r <= buf_nxt;
         ch_r <= ch_nxt;
         pend_r <= pend_nxt;
         reqd_r <= reqd_nxt;
         irq_r <= irq_nxt;
         est_r <= est_nxt;
         eaddr_r <= eaddr_nxt;
         ewr_r <= ewr_nxt;
         eper_r <= eper_nxt;
      end
   end

   // the buffer is handed over as is; the port replicates it onto the byte lanes
   pdmac_ahb_port u_port (
      .clk(CORE_CLK),
      .resetn(RESETN),
      .ce(CLK_EN),
      .start(est_r),
      .is_periph(eper_r),
      .addr_in(eaddr_r),
      .wr_in(ewr_r),
      .size_in(sz),
      .wdata_in(buf_r),
      .done(e_done),
      .err(e_err),
      .rdata(e_rdata),
      .hbusreq(HBUSREQ),
      .hgrant(HGRANT),
      .haddr(HADDR),
      .htrans(HTRANS),
      .hwrite(HWRITE),
      .hsize(HSIZE),
      .hwdata(HWDATA),
      .hrdata(HRDATA),
      .hready(HREADY),
      .hresp(HRESP)
   );

   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY = wready_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   assign S_AXI_RVALID = rvalid_r;
   assign IRQ = irq_r;

   logic moved;
   assign moved = CLK_EN && ch_r == CH_WRITE && e_done && !e_err;

   mar_top_bit_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (CLK_EN && rd_fire && S_AXI_ARADDR == `PDMAC_OFF_MADDR) |=> (S_AXI_RDATA[15] == 1'b0))
      else $error("memory address bit 15 read as one");
   par_base_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (CLK_EN && rd_fire && S_AXI_ARADDR == `PDMAC_OFF_PADDR) |=> (S_AXI_RDATA[31:16] == `PDMAC_PERIPH_BASE))
      else $error("peripheral base half is not fixed");
   moff_step_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      moved |=> (moff_r == 15'($past(moff_r) + $past(inc))))
      else $error("memory offset did not step by the size");
   count_dec_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      moved |=> (cnt == $past(cnt) - 12'h001))
      else $error("transfer count did not drop by one");
   end_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (moved && cnt == 12'h001) |=> (!en && stat_r[`PDMAC_ST_DONE]))
      else $error("end of transfer not flagged");
   err_stop_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (CLK_EN && e_done && e_err && ch_r != CH_IDLE) |=> (!en && stat_r[`PDMAC_ST_ERR]))
      else $error("enable not cleared after an error");
   start_cause_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (CLK_EN && ch_r == CH_IDLE && ch_nxt == CH_READ) |-> (pend_r && en))
      else $error("transfer started without a pending request");
   src_select_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (CLK_EN && est_nxt && ch_r == CH_IDLE && !dir) |=> (eaddr_r[31:16] == `PDMAC_MEM_BASE && !ewr_r))
      else $error("memory not used as source with direction 0");
   align_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (est_r && !eper_r && sz != 2'h0) |-> (eaddr_r[0] == 1'b0 && (sz != 2'h2 || eaddr_r[1] == 1'b0)))
      else $error("memory address not aligned to the size");
endmodule

// *** sim/pdmac_bus_model.sv ***
`timescale 1ns/1ps
// Purpose: AHB bus, memory and peripheral model
// Assumes: another master owns the bus part of the time
// Notes: read data echo the low address half in both halves; idle data are inverted
module pdmac_bus_model (
   input wire logic clk,
   input wire logic breq,
   output logic gnt = 1'h0,
   input wire logic [31:0] ad,
   input wire logic [1:0] tr,
   input wire logic wrt,
   input wire logic [31:0] wdat,
   output logic [31:0] rdat = 32'h0,
   output logic rdy = 1'h1,
   output logic [31:0] wa,
   output logic [31:0] wd,
   output logic [31:0] ra,
   output int nw = 0
);
   logic [2:0] t = 3'h0;
   logic ph = 1'h0;
   logic pw = 1'h0;
   logic [31:0] pa = 32'h0;
   wire np = rdy ? (tr == 2'h2 && !wrt) : (ph && !pw);
   wire [31:0] na = rdy ? ad : pa;
   always @(posedge clk) begin
      t <= t + 3'h1;
      gnt <= breq && (gnt || t[2]);
      rdy <= t != 3'h5;
      rdat <= np ? {na[15:0], na[15:0]} : ~rdat;
      if (rdy) begin
         ph <= tr == 2'h2;
         pa <= ad;
         pw <= wrt;
         if (ph && pw) begin
            wa <= pa;
            wd <= wdat;
            nw <= nw + 1;
         end
         if (ph && !pw) ra <= pa;
      end
   end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// Purpose: register and transfer tests of the DMA channel
// Assumes: bus model on the AHB side
// Notes: clock enable and strobes stay tied; bus error is raised once, at the end
module testbench import pdmac_pkg::*;;
   logic clk = 0, rn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, he = 0;
   logic [7:0] awa = 0, ara = 0;
   logic awr, wr, bv, arr, rv, irq, hbr, hg, hw, hrdy;
   logic [1:0] bresp, rresp, ht, rs;
   logic [2:0] hs;
   logic [31:0] wdt = 0, rd, rdt, ha, hwd, hrd, wa, wd, ra;
   logic [33:0] req = 0, perr = 0;
   int nw, miscompares = 0, compares = 0;
   always #10 clk = ~clk;
   pdmac_channel dut(.CORE_CLK(clk), .RESETN(rn), .CLK_EN(1'h1), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdt), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
      .HBUSREQ(hbr), .HGRANT(hg), .HADDR(ha), .HTRANS(ht), .HWRITE(hw), .HSIZE(hs), .HWDATA(hwd),
      .HRDATA(hrd), .HREADY(hrdy), .HRESP(he), .PERIPH_REQ(req), .PERIPH_ERR(perr), .IRQ(irq));
   pdmac_bus_model bus(.clk(clk), .breq(hbr), .gnt(hg), .ad(ha), .tr(ht), .wrt(hw), .wdat(hwd),
      .rdat(hrd), .rdy(hrdy), .wa(wa), .wd(wd), .ra(ra), .nw(nw));
   task automatic give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wdt <= d;
      {awv, wv, br} <= 3'h7;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wr) wv <= 1'h0;
      end while (!bv);
      rs = bresp;
      br <= 1'h0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      {arv, rr} <= 2'h3;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end while (!rv);
      rd = rdt;
      rs = rresp;
      rr <= 1'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk(rd, e);
   endtask
   // a level held two cycles, so the channel sees one rising edge
   task automatic preq;
      @(posedge clk);
      req[1] <= 1'h1;
      repeat (2) @(posedge clk);
      req[1] <= 1'h0;
   endtask
   task automatic waitw(input int n);
      for (int i = 0; i < 400 && nw != n; i++) @(posedge clk);
      chk(nw, n);
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      give_verdict;
   end
   initial begin
      repeat (2) @(posedge clk);
      rn <= 1'h1;
      rchk(8'h0C, 32'h2000_0000);
      rchk(8'h08, 32'h4000_0000);
      axr(8'h14);
      chk({30'h0, rs}, 32'h2);
      axw(8'h14, 32'h1);
      chk({30'h0, rs}, 32'h2);
      axw(8'h0C, 32'hFFFF_FFFF);
      chk({30'h0, rs}, 32'h0);
      rchk(8'h0C, 32'h2000_7FFF);
      axw(8'h08, 32'hFFFF_0010);
      rchk(8'h08, 32'h4000_0010);
      preq;
      repeat (30) @(posedge clk);
      chk(nw, 0);
      $display("test registers done");
      axw(8'h0C, 32'h3);
      axw(8'h10, 32'h3);
      axw(8'h00, 32'h0002_0106);
      axw(8'h00, 32'h0002_0107);
      preq;
      waitw(1);
      chk({29'h0, hs}, 32'h1);
      chk(wa, 32'h2000_0002);
      chk({16'h0, wd[15:0]}, 32'h10);
      preq;
      waitw(2);
      chk(wa, 32'h2000_0004);
      chk(ra, 32'h4000_0010);
      repeat (10) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rchk(8'h00, 32'h0000_0106);
      rchk(8'h04, 32'h1);
      rchk(8'h0C, 32'h2000_0007);
      chk({31'h0, irq}, 32'h0);
      $display("test halfword done");
      axw(8'h00, 32'h0001_0109);
      preq;
      waitw(3);
      chk({29'h0, hs}, 32'h2);
      chk(ra, 32'h2000_0004);
      chk(wa, 32'h4000_0010);
      chk(wd, 32'h0004_0004);
      repeat (10) @(posedge clk);
      rchk(8'h04, 32'h1);
      axw(8'h00, 32'h0001_8109);
      perr[1] <= 1'h1;
      repeat (10) @(posedge clk);
      rchk(8'h00, 32'h0001_8108);
      rchk(8'h04, 32'h2);
      perr[1] <= 1'h0;
      he <= 1'h1;
      axw(8'h00, 32'h0001_0109);
      preq;
      repeat (20) @(posedge clk);
      rchk(8'h00, 32'h0001_0108);
      rchk(8'h04, 32'h2);
      chk(nw, 3);
      $display("test word and error done");
      give_verdict;
   end
endmodule
